// File: design/switch_lookup_table_access.sv
// Indirect access engine for the lookup, static and reserved multicast tables.
// Assumes a management port giving one request per cycle at most.
`timescale 1ns/1ps
`include "lookup_defs.svh"
module switch_lookup_table_access (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Management register port
  input wire lookup_pkg::reg_req_t mgmt_req,
  output lookup_pkg::reg_rsp_t mgmt_rsp
);
  localparam logic [lookup_pkg::LU_AW-1:0] LU_LAST = '1;

  lookup_pkg::state_t q;
  lookup_pkg::state_t d;
  logic wr;
  logic rd;
  logic clr_rd;
  logic lu_we;
  logic st_we;
  logic rm_we;
  logic lu_hit;
  logic [11:0] hash_idx;
  logic [lookup_pkg::LU_AW-1:0] lu_addr;
  logic [lookup_pkg::ST_AW-1:0] st_addr;
  logic [lookup_pkg::RM_AW-1:0] rm_addr;
  logic [127:0] lu_rdata;
  logic [127:0] st_rdata;
  logic [31:0] rm_rdata;
  logic [31:0] lu_ctrl_w;
  logic [31:0] sm_ctrl_w;
  logic [31:0] idx0_w;

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Request decode
  assign wr = mgmt_req.req && mgmt_req.we;
  assign rd = mgmt_req.req && !mgmt_req.we;
  assign clr_rd = rd && mgmt_req.addr == `OFF_ENTRY4 && mgmt_req.be[`LAST_BYTE_LANE]; // RULE_03

  // Register images
  assign lu_ctrl_w = {2'h0, q.lu_count, 8'h00, q.lu_go, q.lu_valid,
                      q.lu_valid || !q.lu_go, // RULE_04
                      q.lu_rsvd, q.lu_direct, q.lu_act}; // RULE_01
  assign sm_ctrl_w = {10'h000, q.sm_idx, 8'h00, q.sm_go, q.sm_rsvd, q.sm_sel, q.sm_read};
  assign idx0_w = {q.idx_rsvd, 8'h00, q.fgid, q.mac[47:32]};

  // Table addressing
  assign lu_addr = (q.fsm == lookup_pkg::S_IDLE) ?
                   (q.lu_direct ? q.mac[`DIRECT_RANGE] : hash_idx) : q.scan; // RULE_05 RULE_14 RULE_12
  assign st_addr = q.sm_idx[`ST_IDX_RANGE]; // RULE_07
  assign rm_addr = q.sm_idx; // RULE_07
  assign lu_hit = lu_rdata[`ENTRY_VALID_BIT];

  lookup_hash_index u_hash (
    .filter_group_id(q.fgid),
    .mac(q.mac),
    .index(hash_idx)
  );

  lookup_table_mem #(.DW(128), .AW(lookup_pkg::LU_AW)) u_lu_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(lu_we),
    .addr(lu_addr),
    .wdata(q.entry),
    .rdata(lu_rdata)
  );

  lookup_table_mem #(.DW(128), .AW(lookup_pkg::ST_AW)) u_st_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(st_we),
    .addr(st_addr),
    .wdata(q.entry),
    .rdata(st_rdata)
  );

  lookup_table_mem #(.DW(32), .AW(lookup_pkg::RM_AW)) u_rm_mem (
    .sys_clk(sys_clk),
    .rst(rst),
    .we(rm_we),
    .addr(rm_addr),
    .wdata(q.entry[1]),
    .rdata(rm_rdata)
  );

  // Register access and engine next state
  always_comb begin
    logic [31:0] w;
    w = '0;
    d = q;
    d.rsp.ack = mgmt_req.req;
    d.rsp.rdata = '0;
    lu_we = 1'b0;
    st_we = 1'b0;
    rm_we = 1'b0;
    // Reads
    if (rd) begin
      case (mgmt_req.addr)
        `OFF_IDX0: d.rsp.rdata = idx0_w;
        `OFF_IDX1: d.rsp.rdata = q.mac[31:0];
        `OFF_LU_CTRL: d.rsp.rdata = lu_ctrl_w;
        `OFF_SM_CTRL: d.rsp.rdata = sm_ctrl_w;
        `OFF_ENTRY1, `OFF_ENTRY2, `OFF_ENTRY3, `OFF_ENTRY4: begin
          d.rsp.rdata = q.entry[mgmt_req.addr[`ENTRY_SEL_RANGE]];
        end
        default: d.rsp.rdata = '0;
      endcase
    end
    // Writes; control is locked while its operation runs
    if (wr) begin
      case (mgmt_req.addr)
        `OFF_IDX0: begin
          w = merge(idx0_w, mgmt_req.wdata, mgmt_req.be);
          d.idx_rsvd = w[`IDX0_RSVD_BIT];
          d.fgid = w[`FGID_RANGE];
          d.mac[47:32] = w[`MACHI_RANGE];
        end
        `OFF_IDX1: begin
          d.mac[31:0] = merge(q.mac[31:0], mgmt_req.wdata, mgmt_req.be);
        end
        `OFF_LU_CTRL: begin
          w = merge(lu_ctrl_w, mgmt_req.wdata, mgmt_req.be);
          if (!q.lu_go) begin
            d.lu_go = w[`GO_BIT]; // RULE_02
            d.lu_rsvd = w[`LU_RSVD_RANGE];
            d.lu_direct = w[`DIRECT_BIT]; // RULE_05
            d.lu_act = lookup_pkg::lu_action_t'(w[`ACT_RANGE]);
          end
        end
        `OFF_SM_CTRL: begin
          w = merge(sm_ctrl_w, mgmt_req.wdata, mgmt_req.be);
          if (!q.sm_go) begin
            d.sm_go = w[`GO_BIT]; // RULE_08
            d.sm_idx = w[`SM_IDX_RANGE];
            d.sm_rsvd = w[`SM_RSVD_RANGE];
            d.sm_sel = w[`SM_SEL_BIT];
            d.sm_read = w[`SM_READ_BIT];
          end
        end
        `OFF_ENTRY1, `OFF_ENTRY2, `OFF_ENTRY3, `OFF_ENTRY4: begin
          d.entry[mgmt_req.addr[`ENTRY_SEL_RANGE]] =
            merge(q.entry[mgmt_req.addr[`ENTRY_SEL_RANGE]], mgmt_req.wdata, mgmt_req.be);
        end
        default: d.rsp.rdata = '0;
      endcase
    end
    // Software read of the last entry byte consumes the found entry
    if (clr_rd) begin
      d.lu_valid = 1'b0; // RULE_03
    end
    // Engine; its loads and sets come last so they win
    case (q.fsm)
      lookup_pkg::S_IDLE: begin
        if (q.lu_go) begin
          case (q.lu_act) // RULE_06
            lookup_pkg::ACT_WRITE: begin
              lu_we = 1'b1; // RULE_12
              d.lu_go = 1'b0;
            end
            lookup_pkg::ACT_READ: begin
              d.entry = lu_rdata; // RULE_12 RULE_13
              d.lu_go = 1'b0;
            end
            lookup_pkg::ACT_SEARCH: begin
              d.scan = `RST_SCAN;
              d.lu_count = `RST_COUNT;
              d.lu_valid = 1'b0;
              d.fsm = lookup_pkg::S_SCAN;
            end
            default: d.lu_go = 1'b0;
          endcase
        end else if (q.sm_go) begin
          if (q.sm_read) begin // RULE_10
            if (q.sm_sel) begin // RULE_09
              d.entry[1] = rm_rdata; // RULE_11
            end else begin
              d.entry = st_rdata; // RULE_11 RULE_13
            end
          end else begin
            rm_we = q.sm_sel; // RULE_09
            st_we = !q.sm_sel;
          end
          d.sm_go = 1'b0; // RULE_08
        end
      end
      lookup_pkg::S_SCAN: begin
        if (lu_hit) begin
          d.entry = lu_rdata;
          d.lu_valid = 1'b1; // RULE_03
          d.lu_count = q.lu_count + `COUNT_STEP; // RULE_01
          d.fsm = lookup_pkg::S_HOLD;
        end else if (q.scan == LU_LAST) begin
          d.lu_go = 1'b0; // RULE_02
          d.fsm = lookup_pkg::S_IDLE;
        end else begin
          d.scan = q.scan + `SCAN_STEP;
        end
      end
      lookup_pkg::S_HOLD: begin
        if (!q.lu_valid) begin
          if (q.scan == LU_LAST) begin
            d.lu_go = 1'b0; // RULE_02
            d.fsm = lookup_pkg::S_IDLE;
          end else begin
            d.scan = q.scan + `SCAN_STEP;
            d.fsm = lookup_pkg::S_SCAN;
          end
        end
      end
      default: d.fsm = lookup_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mgmt_rsp = q.rsp;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_search_last;
    q.fsm == lookup_pkg::S_SCAN && !lu_hit && q.scan == LU_LAST;
  endsequence

  sequence s_sm_start;
    q.fsm == lookup_pkg::S_IDLE && !q.lu_go && q.sm_go;
  endsequence

  // Search end freezes the count and drops go
  property p_search_end;
    s_search_last |=> !q.lu_go && q.lu_count == $past(q.lu_count) ##1 !q.lu_go;
  endproperty
  a_search_end: assert property (p_search_end) else $error("search end wrong"); // RULE_01

  // Lookup read loads entries and finishes next cycle
  property p_lu_read;
    q.fsm == lookup_pkg::S_IDLE && q.lu_go && q.lu_act == lookup_pkg::ACT_READ
      |=> q.entry == $past(lu_rdata) && !q.lu_go;
  endproperty
  a_lu_read: assert property (p_lu_read) else $error("lookup read wrong"); // RULE_02

  // No-operation touches no table and only drops go
  property p_nop;
    q.fsm == lookup_pkg::S_IDLE && q.lu_go && q.lu_act == lookup_pkg::ACT_NOP
      |-> !lu_we ##1 !q.lu_go;
  endproperty
  a_nop: assert property (p_nop) else $error("no-op wrong"); // RULE_06

  // A hit raises the ready flag with the entry
  property p_hit;
    q.fsm == lookup_pkg::S_SCAN && lu_hit
      |=> q.lu_valid && q.fsm == lookup_pkg::S_HOLD && q.entry == $past(lu_rdata);
  endproperty
  a_hit: assert property (p_hit) else $error("hit not flagged"); // RULE_03

  // Last-byte read consumes the ready flag
  property p_consume;
    q.fsm == lookup_pkg::S_HOLD && clr_rd |=> !q.lu_valid;
  endproperty
  a_consume: assert property (p_consume) else $error("ready not cleared"); // RULE_03

  // Bit 5 answers the combined flag
  property p_either;
    rd && mgmt_req.addr == `OFF_LU_CTRL |=> mgmt_rsp.ack
      && mgmt_rsp.rdata[`EITHER_BIT] == ($past(q.lu_valid) || !$past(q.lu_go));
  endproperty
  a_either: assert property (p_either) else $error("bit 5 wrong"); // RULE_04

  // Direct write location
  property p_direct;
    lu_we && q.lu_direct |-> lu_addr == q.mac[`DIRECT_RANGE];
  endproperty
  a_direct: assert property (p_direct) else $error("direct index wrong"); // RULE_14

  // Hashed write location
  property p_hashed;
    lu_we && !q.lu_direct |-> lu_addr == hash_idx;
  endproperty
  a_hashed: assert property (p_hashed) else $error("hash index wrong"); // RULE_15

  // Static or multicast access completes in one cycle
  property p_sm_done;
    s_sm_start |=> !q.sm_go;
  endproperty
  a_sm_done: assert property (p_sm_done) else $error("access not finished"); // RULE_08

  // Multicast write uses six index bits and the second word
  property p_rm_write;
    rm_we |-> q.sm_sel && !q.sm_read && rm_addr == q.sm_idx && !st_we;
  endproperty
  a_rm_write: assert property (p_rm_write) else $error("multicast write wrong"); // RULE_07
endmodule // switch_lookup_table_access

// File: design/lookup_defs.svh
// Register map, field positions and reset values of the lookup table access block.
// Assumes a byte-addressed management port that carries aligned 32-bit words with per-byte lane enables.
// Overview of operation
// (RULE_01) After a search the count of valid entries reads at control bits 29:16.
// (RULE_02) Writing 1 to control bit 7 starts an operation; hardware clears it when done.
// (RULE_03) Bit 6 rises when a found entry is loaded; reading byte 0x042F clears it.
// (RULE_04) Bit 5 reads entry-ready OR operation-finished.
// (RULE_05) Bit 2 picks direct indexing; zero picks hashed indexing.
// (RULE_06) Action bits 1:0: none, write, read, search.
// (RULE_07) Static/multicast index: six bits for multicast, low four for static.
// (RULE_08) Static/multicast bit 7 starts an access; hardware clears it when done.
// (RULE_09) Bit 1 selects the reserved multicast table, else the static table.
// (RULE_10) Bit 0 makes the access a read, else a write.
// (RULE_11) Static accesses move four entry words; multicast only the second word.
// (RULE_12) Lookup operations take their index from the two index registers; a search instead scans every location from 0 with its own counter.
// (RULE_13) The entry words hold whichever table the current access targets.
// (RULE_14) Direct mode uses the low twelve bits of the lower MAC word.
// (RULE_15) Hashed mode folds the filter group id with the 48-bit MAC index.
// (RULE_16) Software polls bit 7 low before reading results or starting again.
`ifndef LOOKUP_DEFS_SVH
`define LOOKUP_DEFS_SVH
// Byte offsets
`define OFF_IDX0 16'h0410
`define OFF_IDX1 16'h0414
`define OFF_LU_CTRL 16'h0418
`define OFF_SM_CTRL 16'h041C
`define OFF_ENTRY1 16'h0420
`define OFF_ENTRY2 16'h0424
`define OFF_ENTRY3 16'h0428
`define OFF_ENTRY4 16'h042C
`define ENTRY_SEL_RANGE 3:2
// Lookup access control fields
`define COUNT_RANGE 29:16
`define GO_BIT 7
`define VALID_BIT 6
`define EITHER_BIT 5
`define LU_RSVD_RANGE 4:3
`define DIRECT_BIT 2
`define ACT_RANGE 1:0
// Static/multicast control fields
`define SM_IDX_RANGE 21:16
`define ST_IDX_RANGE 3:0
`define SM_RSVD_RANGE 6:2
`define SM_SEL_BIT 1
`define SM_READ_BIT 0
// Index register fields
`define IDX0_RSVD_BIT 31
`define FGID_RANGE 22:16
`define MACHI_RANGE 15:0
`define DIRECT_RANGE 11:0
// Byte lane of address 0x042F, big-endian lane order
`define LAST_BYTE_LANE 0
// Word-1 bit that marks an occupied lookup entry
`define ENTRY_VALID_BIT 31
// Reset values and step sizes
`define RST_COUNT 14'h0000
`define RST_SCAN 12'h000
`define COUNT_STEP 14'h0001
`define SCAN_STEP 12'h001
`endif

// File: design/lookup_pkg.sv
// Types shared by the lookup table access block.
// Assumes the table widths below match the instantiated memories.
package lookup_pkg;
  localparam int LU_AW = 12;
  localparam int ST_AW = 4;
  localparam int RM_AW = 6;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SCAN = 3'h1,
    S_HOLD = 3'h2
  } engine_state_t;

  typedef enum logic [1:0] {
    ACT_NOP = 2'h0,
    ACT_WRITE = 2'h1,
    ACT_READ = 2'h2,
    ACT_SEARCH = 2'h3
  } lu_action_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } reg_rsp_t;

  typedef struct packed {
    engine_state_t fsm;
    logic lu_go;
    logic lu_valid;
    logic lu_direct;
    logic [1:0] lu_rsvd;
    lu_action_t lu_act;
    logic [13:0] lu_count;
    logic [LU_AW-1:0] scan;
    logic idx_rsvd;
    logic [6:0] fgid;
    logic [47:0] mac;
    logic sm_go;
    logic sm_sel;
    logic sm_read;
    logic [4:0] sm_rsvd;
    logic [5:0] sm_idx;
    logic [3:0][31:0] entry;
    reg_rsp_t rsp;
  } state_t;
endpackage

// File: design/lookup_table_mem.sv
// Single-port table storage with combinational read.
// Assumes one write per cycle; contents clear under reset.
`timescale 1ns/1ps
module lookup_table_mem #(
  parameter int DW = 128,
  parameter int AW = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_q [2**AW];

  // Clear on reset, else write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 2**AW; i++) begin
        mem_q[i] <= '0;
      end
    end else if (we) begin
      mem_q[addr] <= wdata;
    end
  end

  // Read port
  assign rdata = mem_q[addr];
endmodule // lookup_table_mem

// File: design/lookup_hash_index.sv
// Folds filter group id and MAC index into a lookup table location.
// Assumes a 12-bit table index.
`timescale 1ns/1ps
module lookup_hash_index (
  // Key
  input wire logic [6:0] filter_group_id,
  input wire logic [47:0] mac,
  // Location
  output logic [11:0] index
);
  // XOR fold of the key
  assign index = mac[11:0] ^ mac[23:12] ^ mac[35:24] ^ mac[47:36]
               ^ {5'h00, filter_group_id}; // RULE_15
endmodule // lookup_hash_index

// File: verification/switch_lookup_table_access_bench.sv
// Self-checking bench for the lookup table access block.
// Assumes the register port contract: ack one cycle after each request, tables clear at reset.
`timescale 1ns/1ps
`include "lookup_defs.svh"
module switch_lookup_table_access_bench;
  // Clock and reset
  logic sys_clk;
  logic rst;
  // Management register port
  lookup_pkg::reg_req_t mgmt_req;
  lookup_pkg::reg_rsp_t mgmt_rsp;
  int failures;
  int checks;

  switch_lookup_table_access dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .mgmt_req(mgmt_req),
    .mgmt_rsp(mgmt_rsp)
  );

  // Free running 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Compares one 32-bit result
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register access; one-cycle request pulse, answer taken at the edge where ack stands
  task automatic bus(input logic we, input logic [15:0] addr, input logic [3:0] be,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge sys_clk);
    mgmt_req <= '{req: 1'b1, we: we, addr: addr, be: be, wdata: wdata};
    @(posedge sys_clk);
    mgmt_req.req <= 1'b0; // Taken at this edge; a longer pulse would be a second access
    mgmt_req.wdata <= ~wdata; // Released data no longer shows the last value
    @(posedge sys_clk);
    check("ack", 32'h00000001, {31'h00000000, mgmt_rsp.ack});
    rdata = mgmt_rsp.rdata;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    bus(1'b1, addr, 4'hF, data, unused);
  endtask

  task automatic rdc(input string what, input logic [15:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, addr, 4'hF, 32'h00000000, got);
    check(what, exp, got);
  endtask

  // Reads addr until bit bitn equals val, bounded
  task automatic poll(input logic [15:0] addr, input int bitn, input logic val);
    logic [31:0] got;
    bit seen;
    seen = 1'b0;
    for (int i = 0; i < 4000; i++) begin
      bus(1'b0, addr, 4'hF, 32'h00000000, got);
      if (got[bitn] === val) begin
        seen = 1'b1;
        break;
      end
    end
    check("poll", 32'h00000001, {31'h00000000, seen});
  endtask

  task automatic set_entries(input logic [3:0][31:0] e);
    for (int i = 0; i < 4; i++) wr(16'h0420 + 16'(i * 4), e[i]);
  endtask

  // Word 4 is read with its last byte lane off, so a found entry is not consumed
  task automatic chk_entries(input logic [3:0][31:0] e);
    logic [31:0] got;
    for (int i = 0; i < 3; i++) rdc("entry", 16'h0420 + 16'(i * 4), e[i]);
    bus(1'b0, 16'h042C, 4'hE, 32'h00000000, got);
    check("entry4", e[3], got);
  endtask

  // Independent fold of filter group id and MAC index
  function automatic logic [11:0] hash12(input logic [6:0] fg, input logic [47:0] mac);
    return mac[11:0] ^ mac[23:12] ^ mac[35:24] ^ mac[47:36] ^ {5'h00, fg};
  endfunction

  localparam logic [3:0][31:0] PAT_D = {32'hD4D4D4D4, 32'hD3D3D3D3, 32'hD2D2D2D2, 32'h8000D1D1};
  localparam logic [3:0][31:0] PAT_H = {32'hA4A4A4A4, 32'hA3A3A3A3, 32'hA2A2A2A2, 32'h8000A1A1};
  localparam logic [3:0][31:0] PAT_S = {32'h44444444, 32'h33333333, 32'h22222222, 32'h12345678};

  // Reset images and unmapped space
  task automatic t_reset();
    rdc("lu ctrl", 16'h0418, 32'h00000020);
    rdc("sm ctrl", 16'h041C, 32'h00000000);
    rdc("idx0", 16'h0410, 32'h00000000);
    chk_entries('0);
    wr(16'h0500, 32'hFFFFFFFF);
    rdc("unmapped", 16'h0500, 32'h00000000);
    $display("test reset done");
  endtask

  // Direct write with junk upper bits, then direct read back
  task automatic t_direct();
    wr(16'h0414, 32'hFFFFFABC);
    set_entries(PAT_D);
    wr(16'h0418, 32'h00000085);
    poll(16'h0418, 7, 1'b0);
    rdc("lu ctrl", 16'h0418, 32'h00000025);
    set_entries('0);
    wr(16'h0414, 32'h00000ABC);
    wr(16'h0418, 32'h00000086);
    poll(16'h0418, 7, 1'b0);
    chk_entries(PAT_D);
    set_entries('0);
    wr(16'h0418, 32'h00000084);
    poll(16'h0418, 7, 1'b0);
    rdc("lu ctrl", 16'h0418, 32'h00000024);
    chk_entries('0);
    $display("test direct done");
  endtask

  // Hashed write, read back directly at the folded location
  task automatic t_hashed();
    wr(16'h0410, 32'h00450000);
    wr(16'h0414, 32'h00000123);
    set_entries(PAT_H);
    wr(16'h0418, 32'h00000081);
    poll(16'h0418, 7, 1'b0);
    set_entries('0);
    wr(16'h0414, {20'h00000, hash12(7'h45, 48'h000000000123)});
    wr(16'h0418, 32'h00000086);
    poll(16'h0418, 7, 1'b0);
    chk_entries(PAT_H);
    $display("test hashed done");
  endtask

  // Search finds both entries in index order and counts them
  task automatic t_search();
    logic [31:0] unused;
    wr(16'h0418, 32'h00000083);
    poll(16'h0418, 6, 1'b1);
    rdc("lu ctrl", 16'h0418, 32'h000100E3);
    chk_entries(PAT_H);
    bus(1'b0, 16'h042C, 4'hE, 32'h00000000, unused);
    rdc("lu ctrl", 16'h0418, 32'h000100E3);
    bus(1'b0, 16'h042C, 4'h1, 32'h00000000, unused);
    rdc("lu ctrl", 16'h0418, 32'h00010083);
    wr(16'h0418, 32'h00000000);
    rdc("lu ctrl", 16'h0418, 32'h00010083);
    poll(16'h0418, 6, 1'b1);
    rdc("lu ctrl", 16'h0418, 32'h000200E3);
    chk_entries(PAT_D);
    bus(1'b0, 16'h042C, 4'hF, 32'h00000000, unused);
    poll(16'h0418, 7, 1'b0);
    rdc("lu ctrl", 16'h0418, 32'h00020023);
    $display("test search done");
  endtask

  // Static table uses four words and the low index bits
  task automatic t_static();
    set_entries(PAT_S);
    wr(16'h041C, 32'h00130080);
    poll(16'h041C, 7, 1'b0);
    rdc("sm ctrl", 16'h041C, 32'h00130000);
    set_entries('0);
    wr(16'h041C, 32'h00030081);
    poll(16'h041C, 7, 1'b0);
    chk_entries(PAT_S);
    $display("test static done");
  endtask

  // Multicast table uses word two only and all six index bits
  task automatic t_mcast();
    wr(16'h0424, 32'h5A5A5A5A);
    wr(16'h041C, 32'h002A0082);
    poll(16'h041C, 7, 1'b0);
    wr(16'h0424, 32'h00000000);
    wr(16'h0420, 32'h11111111);
    wr(16'h041C, 32'h002A0083);
    poll(16'h041C, 7, 1'b0);
    rdc("mc word2", 16'h0424, 32'h5A5A5A5A);
    rdc("mc word1", 16'h0420, 32'h11111111);
    rdc("sm ctrl", 16'h041C, 32'h002A0003);
    wr(16'h041C, 32'h000A0083);
    poll(16'h041C, 7, 1'b0);
    rdc("mc other", 16'h0424, 32'h00000000);
    $display("test multicast done");
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog, well beyond the search and polling time
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    $display("watchdog expired");
    wrap_up();
  end

  // Main sequence
  initial begin
    failures = 0;
    checks = 0;
    rst = 1'b1;
    mgmt_req = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_direct();
    t_hashed();
    t_search();
    t_static();
    t_mcast();
    wrap_up();
  end
endmodule // switch_lookup_table_access_bench
